// ==== adc_core_warmup.sv ====
// ADC core power-up sequencer with warm-up delay, ready flags and a common
// ready interrupt, reached by software over APB.
// Assumes one clock pclk that is also the core source clock, and an APB master.
`include "adc_warmup_defines.svh"

module adc_core_warmup #(
   parameter int ADDR_WIDTH = 8
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [ADDR_WIDTH-1:0]        paddr,
   input  wire adc_warmup_pkg::apb_data_type pwdata,
   input  wire logic [3:0]                   pstrb,
   output      adc_warmup_pkg::apb_data_type prdata,
   output      logic                         pready,
   output      logic                         pslverr,
   output      adc_warmup_pkg::core_vec_type core_power_en,
   output      adc_warmup_pkg::core_vec_type core_ready,
   output      logic                         adc_irq
);
   import adc_warmup_pkg::*;

   // ------------------------------------------------------------------------
   // Elaboration checks.
   // ------------------------------------------------------------------------
   localparam int NUM_CORES = 3;

   // The decoder compares a full byte of address, so narrower buses cannot work.
   if (ADDR_WIDTH < 8) begin : g_check
      $error("ADDR_WIDTH must be at least 8");
   end

   // The core vector carries one bit for each core, in a fixed order.
   if (NUM_CORES != $bits(core_vec_type)) begin : g_core_check
      $error("core vector width must match the core count");
   end

   // ------------------------------------------------------------------------
   // Functions.
   // ------------------------------------------------------------------------
   // Turns the warm-up code into a count of source clock periods.
   // The largest code gives 32768, which still fits the 16-bit counter.
   function automatic delay_count_type warmup_periods(input warmup_code_type code);
      delay_count_type result;
      result = `WARMUP_MIN_PERIODS;
      if (code >= `WARMUP_MIN_CODE) begin
         result = delay_count_type'(16'h0001 << code);
      end
      return result;
   endfunction

   // Places the three core bits at their register positions; other bits read zero.
   function automatic logic [15:0] core_layout(input core_vec_type v);
      logic [15:0] result;
      result = 16'h0000;
      result[`CORE0_BIT]  = v[0];
      result[`CORE1_BIT]  = v[1];
      result[`SHARED_BIT] = v[2];
      return result;
   endfunction

   // Gathers the three core bits from a written word.
   function automatic core_vec_type core_pick(input logic [31:0] w);
      return {w[`SHARED_BIT], w[`CORE1_BIT], w[`CORE0_BIT]};
   endfunction

   // ------------------------------------------------------------------------
   // Registers and state.
   // ------------------------------------------------------------------------
   warmup_code_type warmup_code;
   core_vec_type    ready_irq_en;
   core_vec_type    irq_status;
   core_vec_type    irq_mask;
   core_vec_type    next_ready;

   // ------------------------------------------------------------------------
   // APB decode.
   // ------------------------------------------------------------------------
   wire logic [7:0] addr_low   = paddr[7:0];
   wire logic       upper_zero = (paddr >> 8) == '0;
   wire logic       hit_ctrl   = upper_zero && addr_low == `OFFSET_WARMUP_CTRL;
   wire logic       hit_power  = upper_zero && addr_low == `OFFSET_POWER_READY;
   wire logic       hit_status = upper_zero && addr_low == `OFFSET_IRQ_STATUS;
   wire logic       hit_mask   = upper_zero && addr_low == `OFFSET_IRQ_MASK;
   wire logic       mapped     = hit_ctrl | hit_power | hit_status | hit_mask;
   wire logic       access     = psel & penable & ~pready;
   wire logic       write_done = psel & penable & pready & pwrite & mapped;
   wire logic       lane0      = pstrb[0];
   wire logic       lane1      = pstrb[1];
   wire logic       wr_ctrl    = write_done & hit_ctrl;
   wire logic       wr_power   = write_done & hit_power & lane0;
   wire logic       wr_status  = write_done & hit_status & lane0;
   wire logic       wr_mask    = write_done & hit_mask & lane0;
   wire core_vec_type wdata_cores = core_pick(pwdata);

   // Each field takes its own byte lane, so a partial write leaves the other byte.
   wire logic            wr_code    = wr_ctrl & lane1;
   wire logic            wr_irq_en  = wr_ctrl & lane0;
   wire warmup_code_type wdata_code = pwdata[`WARMUP_CODE_MSB:`WARMUP_CODE_LSB];

   wire logic [15:0] irq_en_word = core_layout(ready_irq_en);
   wire logic [15:0] ctrl_word  = {4'h0, warmup_code, irq_en_word[7:0]};
   wire logic [15:0] power_word = (core_layout(core_ready) << `READY_SHIFT)
                                  | core_layout(core_power_en);
   wire logic [15:0] read_word  = hit_ctrl   ? ctrl_word :
                                  hit_power  ? power_word :
                                  hit_status ? core_layout(irq_status) :
                                  hit_mask   ? core_layout(irq_mask) : 16'h0000;

   // ------------------------------------------------------------------------
   // APB answer: one wait state, then pready for one cycle.
   // ------------------------------------------------------------------------
   // Read data is registered, so it stands settled while pready is high.
   wire logic         read_access = access & ~pwrite;
   wire logic         next_slverr = access & ~mapped;
   wire apb_data_type next_prdata = {16'h0000, read_word};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access;
         pslverr <= next_slverr;
         if (read_access) begin
            prdata <= next_prdata;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Control registers.
   // ------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warmup_code   <= warmup_code_type'(`WARMUP_CTRL_RESET >> `WARMUP_CODE_LSB);
         ready_irq_en  <= `POWER_EN_RESET;
         core_power_en <= `POWER_EN_RESET;
         irq_mask      <= `IRQ_MASK_RESET;
      end else begin
         if (wr_code) begin
            warmup_code <= wdata_code;
         end
         if (wr_irq_en) begin
            ready_irq_en <= wdata_cores;
         end
         if (wr_power) begin
            core_power_en <= wdata_cores;
         end
         if (wr_mask) begin
            irq_mask <= wdata_cores;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Warm-up target.
   // ------------------------------------------------------------------------
   // The code is read live, so changing it during a count moves the target.
   wire delay_count_type delay_target = warmup_periods(warmup_code);
   wire delay_count_type last_count   = delay_target - 16'h0001;

   // ------------------------------------------------------------------------
   // Per-core warm-up counters.
   // ------------------------------------------------------------------------
   // Each core owns its counter, so no register has more than one driver.
   for (genvar i = 0; i < NUM_CORES; i++) begin : g_core
      delay_count_type      count;
      wire logic            powered    = core_power_en[i];
      wire logic            is_ready   = core_ready[i];
      wire logic            counting   = powered & ~is_ready;
      wire logic            expired    = count == last_count;
      wire delay_count_type next_count = !counting ? 16'h0000 :
                                         expired   ? count :
                                         count + 16'h0001;

      // Dropping the power enable clears the flag and restarts the count.
      assign next_ready[i] = powered & (is_ready | expired);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            count <= 16'h0000;
         end else begin
            count <= next_count;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Ready flags, sticky interrupt status and the common interrupt.
   // ------------------------------------------------------------------------
   wire core_vec_type rising_ready = next_ready & ~core_ready;
   wire core_vec_type ready_event  = rising_ready & ready_irq_en;
   wire core_vec_type clear_bits   = wr_status ? wdata_cores : 3'h0;
   // A ready event in the cycle of a clear wins, so no event is lost.
   wire core_vec_type kept_status  = irq_status & ~clear_bits;
   wire core_vec_type next_status  = ready_event | kept_status;
   wire core_vec_type pending      = next_status & irq_mask;
   wire logic         next_irq     = |pending;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_ready <= 3'h0;
         irq_status <= 3'h0;
         adc_irq    <= 1'b0;
      end else begin
         core_ready <= next_ready;
         irq_status <= next_status;
         adc_irq    <= next_irq;
      end
   end

endmodule // adc_core_warmup

// ==== adc_warmup_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the
// ADC core warm-up and ready-interrupt block. Included by its bare name.
`ifndef ADC_WARMUP_DEFINES_SVH
`define ADC_WARMUP_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------------------
`define OFFSET_WARMUP_CTRL   8'h00
`define OFFSET_POWER_READY   8'h04
`define OFFSET_IRQ_STATUS    8'h08
`define OFFSET_IRQ_MASK      8'h0C

// ---------------------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------------------
`define WARMUP_CODE_LSB      8
`define WARMUP_CODE_MSB      11
`define CORE0_BIT            0
`define CORE1_BIT            1
`define SHARED_BIT           7
`define READY_SHIFT          8

// ---------------------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------------------
`define WARMUP_CTRL_RESET    16'h0000
`define POWER_EN_RESET       3'h0
`define IRQ_MASK_RESET       3'h0

// ---------------------------------------------------------------------------
// Timing: the warm-up counts periods of the core source clock, which is pclk.
// ---------------------------------------------------------------------------
`define CORE_SRC_CLK_PERIOD_NS 8
`define WARMUP_MIN_CODE        4'h4
`define WARMUP_MIN_PERIODS     16'h0010

`endif

// ==== adc_warmup_pkg.sv ====
// Types shared by the ADC core warm-up block.
// Assumes the defines header holds the numeric constants.
package adc_warmup_pkg;

   typedef logic [3:0]  warmup_code_type;
   typedef logic [15:0] delay_count_type;
   typedef logic [2:0]  core_vec_type;
   typedef logic [31:0] apb_data_type;

endpackage

// ==== adc_warmup_properties.sv ====
// Port assertions for the ADC core warm-up block.
// Assumes a bind to adc_core_warmup, with pclk as the only clock.
module adc_warmup_properties import adc_warmup_pkg::*; #(parameter int ADDR_WIDTH = 8) (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire apb_data_type          pwdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire core_vec_type          core_power_en,
   input wire core_vec_type          core_ready,
   input wire logic                  adc_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] msk;
   sequence access_wait; psel && penable && !pready; endsequence
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) msk <= '0;
      else if (psel && penable && pready && pwrite && paddr == 8'h0C) msk <= pwdata[7:0];
   a_pready_wait: assert property (access_wait |=> pready) else $error("late pready");
   a_pready_pulse: assert property (pready |=> !pready) else $error("long pready");
   a_slverr_pair: assert property (pslverr |-> pready) else $error("lone pslverr");
   a_slverr_map: assert property (pready |-> pslverr == (paddr > 8'h0C || paddr[1:0] != 2'b00))
      else $error("pslverr wrong");
   a_irq_masked: assert property ({msk[7], msk[1:0]} == 3'b000 |=> !adc_irq)
      else $error("interrupt while masked");
   for (genvar i = 0; i < 3; i++) begin : g_core
      a_off_drops: assert property (!core_power_en[i] |=> !core_ready[i])
         else $error("ready kept after power off");
      a_min_warmup: assert property ($rose(core_ready[i]) |-> $past(core_power_en[i], 15))
         else $error("ready too early");
      a_ready_held: assert property (core_ready[i] && core_power_en[i] |=> core_ready[i])
         else $error("ready lost while powered");
   end
endmodule // adc_warmup_properties
bind adc_core_warmup adc_warmup_properties #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.*);

// ==== adc_core_warmup_ready_irq_test.sv ====
// Self-checking bench for the ADC core warm-up block over APB.
// Assumes package, header, design and checker compile before it.
module adc_core_warmup_ready_irq_test;
   timeunit 1ns / 1ps;
   import adc_warmup_pkg::*;
   logic         pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, adc_irq;
   logic [7:0]   paddr;
   logic [3:0]   pstrb = 4'hF;
   apb_data_type pwdata, prdata;
   core_vec_type core_power_en, core_ready;
   int           bad_count = 0, checks = 0;
   int           plan[6][3] = '{'{0,0,1}, '{3,1,1}, '{4,2,0}, '{5,0,1}, '{7,1,0}, '{15,2,1}};
   adc_core_warmup uut (.*);
   initial forever #4 pclk = ~pclk;
   task automatic chk(input apb_data_type got, exp);
      checks++;
      bad_count += int'(got !== exp);
      if (got !== exp) $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input apb_data_type d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; pready !== 1'b1 && n < 50; n++) @(posedge pclk);
      if (pready !== 1'b1) bad_count++;
      chk(pslverr, a > 8'h0C);
      if (!w) chk(prdata, d);
      {psel, penable} <= 2'b00;
   endtask
   task automatic t_regs;
      for (int a = 0; a < 16; a += 4) apb(1'b0, 8'(a), '0);
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      apb(1'b0, 8'h00, 32'h0000_0F83);
      apb(1'b0, 8'h10, '0);
      $display("test registers done");
   endtask
   task automatic t_warm(input int code, i, en);
      int k = 0;
      apb_data_type m = 32'h1 << (i == 2 ? 7 : i);
      apb(1'b1, 8'h00, code << 8 | (en ? m : '0));
      apb(1'b1, 8'h0C, m);
      apb(1'b1, 8'h04, m);
      apb(1'b1, 8'h04, '0);
      apb(1'b1, 8'h04, m);
      while (core_ready[i] !== 1'b1 && k < 40000) @(posedge pclk) k++;
      chk(k, (code < 4 ? 16 : 1 << code) + 1);
      apb(1'b0, 8'h08, en ? m : '0);
      chk(adc_irq, en);
      apb(1'b0, 8'h04, m | m << 8);
      apb(1'b1, 8'h08, m);
      apb(1'b1, 8'h04, '0);
      chk(adc_irq, 1'b0);
      $display("test warm-up code %0d core %0d done", code, i);
   endtask
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      foreach (plan[j]) t_warm(plan[j][0], plan[j][1], plan[j][2]);
      final_report;
   end
   initial begin
      repeat (80000) @(posedge pclk);
      bad_count++;
      final_report;
   end
endmodule // adc_core_warmup_ready_irq_test
